// File: hdl/cgc_pkg.sv
package cgc_pkg;
    // Sizes of the gain store
    localparam int RAW_W = 12;
    localparam int TGT_N = 10;
    localparam int ENT_N = 2 * TGT_N;
    localparam int GAIN_BUS_W = TGT_N * RAW_W;
    localparam int FRAC_BITS = 4;
    // Picker layout: group in [5:4], target code in [3:0]
    localparam logic [1:0] GRP_PLAIN = 2'h0;
    localparam logic [1:0] GRP_ANALOG = 2'h1;
    localparam logic [1:0] GRP_DIGITAL = 2'h2;
    localparam logic [3:0] CODE_ALL = 4'h0;
    localparam logic [3:0] CODE_LAST = 4'hA;
    localparam logic [4:0] TGT_FIRST_SENSOR_TAP = 5'h06;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PICK = 8'h04;
    localparam logic [7:0] OFS_INT = 8'h08;
    localparam logic [7:0] OFS_PHYS = 8'h0C;
    localparam logic [7:0] OFS_AUTO = 8'h10;
    localparam logic [7:0] OFS_MATCH = 8'h14;
    localparam logic [7:0] OFS_OSEL = 8'h18;
    localparam logic [7:0] OFS_TARGET = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // Reset values and match tolerance
    localparam logic [RAW_W-1:0] RAW_RST = 12'h010;
    localparam logic [RAW_W-1:0] TARGET_RST = 12'h800;
    localparam logic [RAW_W-1:0] TOL = 12'h008;
    // Scan tick timing
    localparam int CLK_PS = 5000;
    localparam int TICK_NS = 1280;
    localparam int TICK_CYC = (TICK_NS * 1000) / CLK_PS;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Adjustment modes
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_ONCE = 2'b01,
        MODE_CONT = 2'b10,
        MODE_HOLD = 2'b11
    } cgc_mode_e;
endpackage

// File: hdl/cgc_conv_if.sv
`timescale 1ns/1ps
interface cgc_conv_if;
    logic [cgc_pkg::RAW_W-1:0] raw_in;
    logic [31:0] phys_out;
    logic [31:0] phys_in;
    logic [cgc_pkg::RAW_W-1:0] raw_out;
    modport conv (input raw_in, input phys_in, output phys_out, output raw_out);
    modport user (output raw_in, output phys_in, input phys_out, input raw_out);
endinterface

// File: hdl/cgc_gain_conv.sv
`timescale 1ns/1ps
module cgc_gain_conv (
    // Conversion port
    cgc_conv_if.conv cv
);
    // Integer to single float, value is raw / 2^FRAC_BITS
    always_comb begin
        logic [4:0] msb;
        logic [34:0] sh;
        msb = 5'h00;
        sh = 35'h0_0000_0000;
        for (int i = 0; i < cgc_pkg::RAW_W; i++) begin
            if (cv.raw_in[i]) begin
                msb = 5'(i);
            end
        end
        sh = {cv.raw_in, 23'h00_0000} >> msb;
        if (cv.raw_in == '0) begin
            cv.phys_out = 32'h0000_0000;
        end else begin
            cv.phys_out = {1'b0, 8'(127 - cgc_pkg::FRAC_BITS + int'(msb)), sh[22:0]};
        end
    end

    // Single float to integer, truncating and saturating
    always_comb begin
        int shamt;
        logic [23:0] mant;
        shamt = int'(cv.phys_in[30:23]) - 127 + cgc_pkg::FRAC_BITS;
        mant = {1'b1, cv.phys_in[22:0]};
        if (cv.phys_in[31] || shamt < 0) begin
            cv.raw_out = '0;
        end else if (shamt >= cgc_pkg::RAW_W) begin
            cv.raw_out = '1;
        end else begin
            cv.raw_out = cgc_pkg::RAW_W'(mant >> (23 - shamt));
        end
    end
endmodule

// File: hdl/cgc_top.sv
`timescale 1ns/1ps
module cgc_top (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Gain values in effect
    output logic [cgc_pkg::GAIN_BUS_W-1:0] analog_gain_o,
    output logic [cgc_pkg::GAIN_BUS_W-1:0] digital_gain_o,
    // Level measurement
    output logic [4:0] measure_index_o,
    input wire logic [cgc_pkg::RAW_W-1:0] measure_level_i,
    // Black-level channel choice
    output logic [3:0] offset_channel_picker_o
);
    localparam int W = cgc_pkg::RAW_W;

    // Per-entry store, analog entries first then digital
    logic [W-1:0] raw_reg [cgc_pkg::ENT_N];
    logic [W-1:0] raw_next [cgc_pkg::ENT_N];
    logic [1:0] mode_reg [cgc_pkg::ENT_N];
    logic [1:0] mode_next [cgc_pkg::ENT_N];
    // Configuration
    logic dual_reg, dual_next;
    logic stage_reg, stage_next;
    logic [5:0] pick_reg, pick_next;
    logic [3:0] osel_reg, osel_next;
    logic [W-1:0] target_reg, target_next;
    logic [1:0] match_reg, match_next;
    logic [W-1:0] ref_reg, ref_next;
    logic moved_reg, moved_next;
    // Scan
    logic [8:0] tick_cnt_reg, tick_cnt_next;
    logic [4:0] scan_reg, scan_next;
    logic tick;
    // Bus
    logic aw_hold_reg, aw_hold_next;
    logic w_hold_reg, w_hold_next;
    logic [7:0] waddr_reg, waddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic do_write, wr_err;
    logic [31:0] wr_val, wmask;
    // Picker decode
    logic pick_ok, cur_stage, cur_all;
    logic [4:0] cur_tgt, cur_ent, scan_tgt;
    logic auto_any;

    cgc_conv_if cv ();

    cgc_gain_conv u_conv (
        .cv(cv)
    );

    function automatic logic [4:0] ent(input logic st, input logic [4:0] t);
        return 5'(int'(st) * cgc_pkg::TGT_N + int'(t));
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return a <= cgc_pkg::OFS_STATUS;
    endfunction

    // Picker code checks, plain only on single stage, prefixed only on dual
    function automatic logic code_ok(input logic [5:0] p, input logic dual);
        logic grp_ok;
        grp_ok = dual ? (p[5:4] == cgc_pkg::GRP_ANALOG || p[5:4] == cgc_pkg::GRP_DIGITAL)
                      : (p[5:4] == cgc_pkg::GRP_PLAIN);
        return grp_ok && p[3:0] <= cgc_pkg::CODE_LAST;
    endfunction

    // Decode the picked stage and target
    always_comb begin
        pick_ok = code_ok(pick_reg, dual_reg);
        cur_stage = (pick_reg[5:4] == cgc_pkg::GRP_PLAIN) ? stage_reg
                  : (pick_reg[5:4] == cgc_pkg::GRP_DIGITAL);
        cur_all = (pick_reg[3:0] == cgc_pkg::CODE_ALL);
        cur_tgt = cur_all ? 5'h00 : 5'({1'b0, pick_reg[3:0]} - 5'h01);
        cur_ent = ent(cur_stage, cur_tgt);
        scan_tgt = (scan_reg >= 5'(cgc_pkg::TGT_N)) ? 5'(scan_reg - 5'(cgc_pkg::TGT_N))
                                                    : scan_reg;
        auto_any = 1'b0;
        for (int e = 0; e < cgc_pkg::ENT_N; e++) begin
            if (mode_reg[e] == cgc_pkg::MODE_ONCE || mode_reg[e] == cgc_pkg::MODE_CONT) begin
                auto_any = 1'b1;
            end
        end
        cv.raw_in = raw_reg[cur_ent];
        cv.phys_in = wr_val;
    end

    // Register read view
    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case ({a[7:2], 2'b00})
            cgc_pkg::OFS_CTRL: v = 32'({stage_reg, dual_reg});
            cgc_pkg::OFS_PICK: v = 32'(pick_reg);
            cgc_pkg::OFS_INT: v = 32'(raw_reg[cur_ent]);
            cgc_pkg::OFS_PHYS: v = cv.phys_out;
            cgc_pkg::OFS_AUTO: v = 32'(mode_reg[cur_ent]);
            cgc_pkg::OFS_MATCH: v = 32'(match_reg);
            cgc_pkg::OFS_OSEL: v = 32'(osel_reg);
            cgc_pkg::OFS_TARGET: v = 32'(target_reg);
            cgc_pkg::OFS_STATUS: v = 32'({match_reg != cgc_pkg::MODE_OFF, auto_any, pick_ok});
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Byte-lane merge of the pending write
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{wstrb_reg[b]}};
        end
        wr_val = (read_word(waddr_reg) & ~wmask) | (wdata_reg & wmask);
    end

    // Scan tick divider and entry walker
    always_comb begin
        tick = (tick_cnt_reg == 9'(cgc_pkg::TICK_CYC - 1));
        tick_cnt_next = tick ? 9'h000 : 9'(tick_cnt_reg + 9'h001);
        scan_next = scan_reg;
        if (tick) begin
            scan_next = (scan_reg == 5'(cgc_pkg::ENT_N - 1)) ? 5'h00 : 5'(scan_reg + 5'h01);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            tick_cnt_reg <= 9'h000;
            scan_reg <= 5'h00;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            scan_reg <= scan_next;
        end
    end

    // Gain store, automatic adjustment and software writes
    always_comb begin
        logic [W:0] lvl, lo, hi;
        logic step;
        logic [4:0] e;
        raw_next = raw_reg;
        mode_next = mode_reg;
        dual_next = dual_reg;
        stage_next = stage_reg;
        pick_next = pick_reg;
        osel_next = osel_reg;
        target_next = target_reg;
        match_next = match_reg;
        ref_next = ref_reg;
        moved_next = moved_reg;
        wr_err = 1'b0;
        step = 1'b0;
        e = scan_reg;
        lvl = {1'b0, measure_level_i};
        lo = {1'b0, target_reg};
        hi = 13'({1'b0, target_reg} + {1'b0, cgc_pkg::TOL});
        if (tick) begin
            if (mode_reg[e] == cgc_pkg::MODE_ONCE || mode_reg[e] == cgc_pkg::MODE_CONT) begin
                if (13'(lvl + {1'b0, cgc_pkg::TOL}) < lo) begin
                    if (raw_reg[e] != '1) raw_next[e] = W'(raw_reg[e] + 1'b1);
                end else if (lvl > hi) begin
                    if (raw_reg[e] != '0) raw_next[e] = W'(raw_reg[e] - 1'b1);
                end else if (mode_reg[e] == cgc_pkg::MODE_ONCE) begin
                    mode_next[e] = cgc_pkg::MODE_OFF;
                end
            end else if ((match_reg == cgc_pkg::MODE_ONCE || match_reg == cgc_pkg::MODE_CONT)
                         && scan_tgt > cgc_pkg::TGT_FIRST_SENSOR_TAP) begin
                // Entries in off or hold follow matching here; match off and hold leave them alone
                if (13'(lvl + {1'b0, cgc_pkg::TOL}) < {1'b0, ref_reg}) begin
                    if (raw_reg[e] != '1) raw_next[e] = W'(raw_reg[e] + 1'b1);
                    step = 1'b1;
                end else if (lvl > 13'({1'b0, ref_reg} + {1'b0, cgc_pkg::TOL})) begin
                    if (raw_reg[e] != '0) raw_next[e] = W'(raw_reg[e] - 1'b1);
                    step = 1'b1;
                end
            end
            if (scan_tgt == cgc_pkg::TGT_FIRST_SENSOR_TAP) begin
                ref_next = measure_level_i;
            end
            moved_next = moved_reg | step;
            if (scan_reg == 5'(cgc_pkg::ENT_N - 1)) begin
                if (match_reg == cgc_pkg::MODE_ONCE && !(moved_reg | step)) begin
                    match_next = cgc_pkg::MODE_OFF;
                end
                moved_next = 1'b0;
            end
        end
        // Software writes land after the engine, so the newer command wins
        if (do_write) begin
            case ({waddr_reg[7:2], 2'b00})
                cgc_pkg::OFS_CTRL: begin
                    dual_next = wr_val[0];
                    stage_next = wr_val[1];
                end
                cgc_pkg::OFS_PICK: begin
                    if (code_ok(wr_val[5:0], dual_reg) && wr_val[31:6] == '0) begin
                        pick_next = wr_val[5:0];
                    end else begin
                        wr_err = 1'b1;
                    end
                end
                cgc_pkg::OFS_INT, cgc_pkg::OFS_PHYS, cgc_pkg::OFS_AUTO: begin
                    if (!pick_ok) begin
                        wr_err = 1'b1;
                    end else begin
                        for (int t = 0; t < cgc_pkg::TGT_N; t++) begin
                            if (cur_all || 5'(t) == cur_tgt) begin
                                if (waddr_reg[7:2] == cgc_pkg::OFS_INT[7:2]) begin
                                    raw_next[ent(cur_stage, 5'(t))] = wr_val[W-1:0];
                                end else if (waddr_reg[7:2] == cgc_pkg::OFS_PHYS[7:2]) begin
                                    raw_next[ent(cur_stage, 5'(t))] = cv.raw_out;
                                end else begin
                                    mode_next[ent(cur_stage, 5'(t))] = wr_val[1:0];
                                end
                            end
                        end
                    end
                end
                cgc_pkg::OFS_MATCH: match_next = wr_val[1:0];
                cgc_pkg::OFS_OSEL: begin
                    if (wr_val[31:0] <= 32'(cgc_pkg::CODE_LAST)) begin
                        osel_next = wr_val[3:0];
                    end else begin
                        wr_err = 1'b1;
                    end
                end
                cgc_pkg::OFS_TARGET: target_next = wr_val[W-1:0];
                default: wr_err = 1'b1;
            endcase
        end
    end

    // Per-entry and configuration state registers
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < cgc_pkg::ENT_N; i++) begin
                raw_reg[i] <= cgc_pkg::RAW_RST;
                mode_reg[i] <= cgc_pkg::MODE_OFF;
            end
            dual_reg <= 1'b0;
            stage_reg <= 1'b0;
            pick_reg <= 6'h00;
            osel_reg <= 4'h0;
            target_reg <= cgc_pkg::TARGET_RST;
            match_reg <= cgc_pkg::MODE_OFF;
            ref_reg <= 12'h000;
            moved_reg <= 1'b0;
        end else begin
            raw_reg <= raw_next;
            mode_reg <= mode_next;
            dual_reg <= dual_next;
            stage_reg <= stage_next;
            pick_reg <= pick_next;
            osel_reg <= osel_next;
            target_reg <= target_next;
            match_reg <= match_next;
            ref_reg <= ref_next;
            moved_reg <= moved_next;
        end
    end

    // AXI4-Lite channel handling
    always_comb begin
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
        if (s_axi_awvalid_i && !aw_hold_reg) begin
            aw_hold_next = 1'b1;
            waddr_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_hold_reg) begin
            w_hold_next = 1'b1;
            wdata_next = s_axi_wdata_i;
            wstrb_next = s_axi_wstrb_i;
        end
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (wr_err || !addr_ok(waddr_reg)) ? cgc_pkg::RESP_SLVERR
                                                          : cgc_pkg::RESP_OKAY;
        end else if (bvalid_reg && s_axi_bready_i) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid_i && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rdata_next = read_word(s_axi_araddr_i);
            rresp_next = addr_ok(s_axi_araddr_i) ? cgc_pkg::RESP_OKAY : cgc_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready_i) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= 2'h0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // Bus outputs
    assign s_axi_awready_o = !aw_hold_reg;
    assign s_axi_wready_o = !w_hold_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign measure_index_o = scan_reg;
    assign offset_channel_picker_o = osel_reg;

    // Gain stage outputs straight from the store
    genvar g;
    for (g = 0; g < cgc_pkg::TGT_N; g++) begin : g_out
        assign analog_gain_o[g*W +: W] = raw_reg[g];
        assign digital_gain_o[g*W +: W] = raw_reg[g + cgc_pkg::TGT_N];
    end
endmodule

// File: sim/cgc_properties.sv
`timescale 1ns/1ps
module cgc_properties (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Bus handshakes
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    // Block outputs
    input wire logic [cgc_pkg::GAIN_BUS_W-1:0] analog_gain_o,
    input wire logic [4:0] measure_index_o,
    input wire logic [3:0] offset_channel_picker_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    logic [8:0] dwell_reg, dwell_next;
    logic [4:0] idx_reg;
    logic seen_reg, seen_next, moved;
    // Cycles spent on one scan entry
    assign moved = measure_index_o != idx_reg;
    always_comb begin
        dwell_next = moved ? 9'h000 : dwell_reg + 9'h001;
        seen_next = seen_reg | moved;
    end
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            dwell_reg <= 9'h000;
            seen_reg <= 1'h0;
            idx_reg <= 5'h00;
        end else begin
            dwell_reg <= dwell_next;
            seen_reg <= seen_next;
            idx_reg <= measure_index_o;
        end
    end
    // Bus timing and holding
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
        s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("late bvalid");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("late rvalid");
    a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata dropped");
    a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped");
    a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("arready during rvalid");
    a_aw_refused: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
        s_axi_wready_o |=> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write ready while held");
    // Engine scan and reset values
    a_scan_order: assert property ($changed(measure_index_o) |-> measure_index_o ==
        ($past(measure_index_o) == 5'h13 ? 5'h00 : $past(measure_index_o) + 5'h01))
        else $error("scan order broken");
    a_scan_dwell: assert property (moved && seen_reg |->
        dwell_reg == 9'(cgc_pkg::TICK_CYC - 1)) else $error("tick period wrong");
    a_reset_gains: assert property ($rose(reset_n_i) |->
        analog_gain_o == {cgc_pkg::TGT_N{cgc_pkg::RAW_RST}}) else $error("gain reset wrong");
    a_offset_range: assert property (offset_channel_picker_o <= 4'hA)
        else $error("offset picker out of range");
    c_write_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == cgc_pkg::RESP_SLVERR);
    c_read_done: cover property (s_axi_rvalid_o && s_axi_rready_i);
    c_scan_wrap: cover property (moved && measure_index_o == 5'h00);
endmodule
bind cgc_top cgc_properties i_cgc_properties (.*);

// File: sim/camera_gain_control_tb.sv
`timescale 1ns/1ps
module camera_gain_control_tb;
    logic clock_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic [7:0] s_axi_awaddr_i = 8'h00;
    logic [7:0] s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i = 1'h0;
    logic s_axi_wvalid_i = 1'h0;
    logic s_axi_bready_i = 1'h0;
    logic s_axi_arvalid_i = 1'h0;
    logic s_axi_rready_i = 1'h0;
    logic [cgc_pkg::RAW_W-1:0] measure_level_i = 12'h800;
    logic [cgc_pkg::RAW_W-1:0] lvl = 12'h800;
    logic skew = 1'h0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rr;
    logic [31:0] s_axi_rdata_o, rv;
    logic [cgc_pkg::GAIN_BUS_W-1:0] analog_gain_o, digital_gain_o, ea, ed;
    logic [4:0] measure_index_o;
    logic [3:0] offset_channel_picker_o;
    int bad_count = 0;
    int num_checks = 0;
    // Clock and level source, analog tap seven reads low while skewed
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) measure_level_i <= (skew && measure_index_o == 5'h07) ? 12'h700 : lvl;
    cgc_top i_cgc_top (.*);
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(string n, logic [cgc_pkg::GAIN_BUS_W-1:0] s, e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic tmo(int n);
        if (n > 12000) begin
            bad_count++;
            close_out();
        end
    endtask
    // Bounded wait for a ready or valid, checked 1 ns after each rising edge
    task automatic wt(int k);
        int n;
        n = 0;
        while ((k == 0 ? s_axi_awready_o & s_axi_wready_o : k == 1 ? s_axi_bvalid_o :
            k == 2 ? s_axi_arready_o : s_axi_rvalid_o) !== 1'h1) begin
            @(posedge clock_i);
            #1;
            n++;
            tmo(n);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = 2'h0);
        @(posedge clock_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        #1;
        wt(0);
        @(posedge clock_i);
        s_axi_awvalid_i <= 1'h0;
        s_axi_wvalid_i <= 1'h0;
        s_axi_bready_i <= 1'h1;
        #1;
        wt(1);
        chk("bresp", s_axi_bresp_o, er);
        @(posedge clock_i);
        s_axi_bready_i <= 1'h0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clock_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        #1;
        wt(2);
        @(posedge clock_i);
        s_axi_arvalid_i <= 1'h0;
        s_axi_rready_i <= 1'h1;
        #1;
        wt(3);
        rv = s_axi_rdata_o;
        rr = s_axi_rresp_o;
        @(posedge clock_i);
        s_axi_rready_i <= 1'h0;
    endtask
    task automatic rc(logic [7:0] a, logic [31:0] e);
        rd(a);
        chk("rdata", rv, e);
        chk("rresp", rr, cgc_pkg::RESP_OKAY);
    endtask
    // Poll a register until it reads the expected value
    task automatic pm(logic [7:0] a, logic [31:0] e);
        int n;
        n = 0;
        do begin
            rd(a);
            n++;
            tmo(n);
        end while (rv !== e);
    endtask
    // Wait for one analog gain field to reach a value
    task automatic wg(int t, logic [11:0] e);
        int n;
        n = 0;
        while (analog_gain_o[t*12+:12] !== e) begin
            @(posedge clock_i);
            #1;
            n++;
            tmo(n);
        end
        chk("ag", analog_gain_o, ea);
    endtask
    task automatic t_plain();
        ea = {cgc_pkg::TGT_N{cgc_pkg::RAW_RST}};
        ed = ea;
        chk("dg", digital_gain_o, ed);
        rc(cgc_pkg::OFS_TARGET, 32'h0000_0800);
        wr(cgc_pkg::OFS_INT, 32'h0000_0123);
        ea = {cgc_pkg::TGT_N{12'h123}};
        chk("ag", analog_gain_o, ea);
        for (int c = 1; c <= 10; c++) begin
            wr(cgc_pkg::OFS_PICK, c);
            wr(cgc_pkg::OFS_INT, 32'h0000_0200 + c);
            ea[(c-1)*12+:12] = 12'h200 + 12'(c);
            rc(cgc_pkg::OFS_INT, 32'h0000_0200 + c);
        end
        chk("ag", analog_gain_o, ea);
        chk("dg", digital_gain_o, ed);
        $display("end plain");
    endtask
    task automatic t_dual();
        wr(cgc_pkg::OFS_CTRL, 32'h0000_0003);
        wr(cgc_pkg::OFS_PICK, 32'h0000_0001, cgc_pkg::RESP_SLVERR);
        wr(cgc_pkg::OFS_PICK, 32'h0000_0012);
        wr(cgc_pkg::OFS_INT, 32'h0000_0055);
        ea[23:12] = 12'h055;
        wr(cgc_pkg::OFS_PICK, 32'h0000_0020);
        wr(cgc_pkg::OFS_INT, 32'h0000_0077);
        wr(cgc_pkg::OFS_PICK, 32'h0000_0027);
        wr(cgc_pkg::OFS_INT, 32'h0000_0066);
        ed = {cgc_pkg::TGT_N{12'h077}};
        ed[83:72] = 12'h066;
        chk("ag", analog_gain_o, ea);
        chk("dg", digital_gain_o, ed);
        wr(cgc_pkg::OFS_CTRL, 32'h0000_0000);
        rc(cgc_pkg::OFS_STATUS, 32'h0000_0000);
        wr(cgc_pkg::OFS_INT, 32'h0000_0005, cgc_pkg::RESP_SLVERR);
        wr(cgc_pkg::OFS_PICK, 32'h0000_0001);
        wr(cgc_pkg::OFS_PHYS, 32'h4060_0000);
        rc(cgc_pkg::OFS_INT, 32'h0000_0038);
        wr(cgc_pkg::OFS_PHYS, 32'hBF80_0000);
        rc(cgc_pkg::OFS_INT, 32'h0000_0000);
        wr(cgc_pkg::OFS_INT, 32'h0000_0020);
        rc(cgc_pkg::OFS_PHYS, 32'h4000_0000);
        ea[11:0] = 12'h020;
        wr(cgc_pkg::OFS_CTRL, 32'h0000_0002);
        wr(cgc_pkg::OFS_INT, 32'h0000_0044);
        ed[11:0] = 12'h044;
        chk("dg", digital_gain_o, ed);
        chk("ag", analog_gain_o, ea);
        wr(cgc_pkg::OFS_CTRL, 32'h0000_0000);
        $display("end dual");
    endtask
    task automatic t_auto();
        wr(cgc_pkg::OFS_PICK, 32'h0000_0002);
        for (int m = 0; m < 4; m++) begin
            wr(cgc_pkg::OFS_AUTO, m);
            rc(cgc_pkg::OFS_AUTO, m);
        end
        wr(cgc_pkg::OFS_PICK, 32'h0000_0001);
        rc(cgc_pkg::OFS_AUTO, 32'h0000_0000);
        wr(cgc_pkg::OFS_INT, 32'h0000_0100);
        ea[11:0] = 12'h100;
        wr(cgc_pkg::OFS_AUTO, 32'h0000_0001);
        pm(cgc_pkg::OFS_AUTO, 32'h0000_0000);
        lvl <= 12'h100;
        wr(cgc_pkg::OFS_AUTO, 32'h0000_0002);
        rc(cgc_pkg::OFS_STATUS, 32'h0000_0003);
        ea[11:0] = 12'h101;
        wg(0, 12'h101);
        ea[11:0] = 12'h102;
        wg(0, 12'h102);
        wr(cgc_pkg::OFS_AUTO, 32'h0000_0000);
        lvl <= 12'h800;
        skew <= 1'h1;
        repeat (5200) @(posedge clock_i);
        chk("ag", analog_gain_o, ea);
        wr(cgc_pkg::OFS_MATCH, 32'h0000_0002);
        rc(cgc_pkg::OFS_STATUS, 32'h0000_0005);
        ea[95:84] = 12'h209;
        wg(7, 12'h209);
        ea[95:84] = 12'h20A;
        wg(7, 12'h20A);
        skew <= 1'h0;
        wr(cgc_pkg::OFS_MATCH, 32'h0000_0001);
        pm(cgc_pkg::OFS_MATCH, 32'h0000_0000);
        chk("dg", digital_gain_o, ed);
        $display("end auto");
    endtask
    task automatic t_bad();
        rd(8'h24);
        chk("rd", rv, 32'h0000_0000);
        chk("rr", rr, cgc_pkg::RESP_SLVERR);
        wr(8'h30, 32'h0000_0001, cgc_pkg::RESP_SLVERR);
        wr(cgc_pkg::OFS_OSEL, 32'h0000_000B, cgc_pkg::RESP_SLVERR);
        wr(cgc_pkg::OFS_OSEL, 32'h0000_0005);
        chk("osel", offset_channel_picker_o, 4'h5);
        $display("end bad");
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        reset_n_i <= 1'h1;
        t_plain();
        t_dual();
        t_auto();
        t_bad();
        close_out();
    end
endmodule
